// file: logic/bmio_pkg.sv
/*
 * Constants for the board memory and I/O decoder: address windows,
 * I/O port offsets, field positions, wait counts and reset values.
 * Assumes a 28-bit byte address from the processor's external bus.
 */
package bmio_pkg;
    localparam int BMIO_AW = 28;
    localparam logic [27:0] BMIO_ROM_LO = 28'h000_0000;
    localparam logic [27:0] BMIO_ROM_HI = 28'h03F_FFFF;
    localparam logic [27:0] BMIO_SRAM_LO = 28'h040_0000;
    localparam logic [27:0] BMIO_SRAM_HI = 28'h07F_FFFF;
    localparam logic [27:0] BMIO_SDRAM_LO = 28'h080_0000;
    localparam logic [27:0] BMIO_SDRAM_HI = 28'h3FF_FFFF;
    localparam logic [27:0] BMIO_XS5_LO = 28'h400_0000;
    localparam logic [27:0] BMIO_XS0_LO = 28'h500_0000;
    localparam logic [27:0] BMIO_XS13_LO = 28'h600_0000;
    localparam logic [27:0] BMIO_XS13_HI = 28'h6FF_FFFF;
    localparam logic [27:0] BMIO_IO_LO = 28'h700_0000;
    localparam logic [27:0] BMIO_UNUSED_LO = 28'h800_0000;
    localparam logic [27:0] BMIO_UNUSED_HI = 28'hFFF_FFFF;
    localparam logic [27:0] BMIO_REGION_MASK = 28'hF00_0000;
    // Board I/O ports
    localparam logic [27:0] BMIO_BOARD_LO = 28'h780_0000;
    localparam logic [27:0] BMIO_BOARD_HI = 28'h780_FFFF;
    localparam logic [27:0] BMIO_SWA = 28'h780_0000;
    localparam logic [27:0] BMIO_SWB = 28'h780_1000;
    localparam logic [27:0] BMIO_SEG = 28'h780_2000;
    localparam logic [27:0] BMIO_SEG_HI_BYTE = 28'h780_2001;
    localparam logic [27:0] BMIO_TOV_CLR = 28'h780_3000;
    localparam logic [27:0] BMIO_IRQ_MASK = 28'h780_4000;
    localparam logic [27:0] BMIO_IRQ_STAT = 28'h780_4010;
    localparam logic [27:0] BMIO_IRQ_CTRL = 28'h780_4020;
    localparam logic [27:0] BMIO_UART_LO = 28'h780_7000;
    localparam logic [27:0] BMIO_UART_HI = 28'h780_7070;
    localparam logic [27:0] BMIO_TIMER_LO = 28'h780_8000;
    localparam logic [27:0] BMIO_TIMER_HI = 28'h780_8030;
    localparam logic [27:0] BMIO_XACC = 28'h780_9000;
    // Wait counts
    localparam logic [3:0] BMIO_ROM_WAIT_FAST = 4'h7;
    localparam logic [3:0] BMIO_ROM_WAIT_SLOW = 4'h5;
    localparam logic [3:0] BMIO_IO_WAIT_FAST = 4'hA;
    localparam logic [3:0] BMIO_IO_WAIT_SLOW = 4'h7;
    // Interrupt collector fields, reset values and sequencer states
    localparam int BMIO_NSRC = 4;
    localparam int BMIO_SRC_TIMER = 0;
    localparam int BMIO_SRC_UART = 1;
    localparam int BMIO_SRC_TOV = 2;
    localparam int BMIO_SRC_XINT = 3;
    localparam int BMIO_CTRL_GATE = 0;
    localparam int BMIO_CTRL_SEL = 1;
    localparam logic [7:0] BMIO_MASK_RST = 8'h00;
    localparam logic [1:0] BMIO_CTRL_RST = 2'h0;
    localparam logic [15:0] BMIO_SEG_RST = 16'hFFFF;
    typedef enum logic [1:0] {BMIO_IDLE, BMIO_WAIT, BMIO_DONE} bmio_state_e;
endpackage : bmio_pkg

// file: logic/bmio_irq_if.sv
/*
 * Carrier between the decoder and its interrupt collector.
 * Assumes both ends on clk_i.
 */
interface bmio_irq_if;
    logic [3:0] src;
    logic [3:0] mask_wdata;
    logic mask_we;
    logic [3:0] clr;
    logic [1:0] ctrl_wdata;
    logic ctrl_we;
    logic [3:0] mask;
    logic [3:0] pending;
    logic [1:0] ctrl;
    modport ctl (output src, mask_wdata, mask_we, clr, ctrl_wdata, ctrl_we,
                 input mask, pending, ctrl);
    modport col (input src, mask_wdata, mask_we, clr, ctrl_wdata, ctrl_we,
                 output mask, pending, ctrl);
endinterface : bmio_irq_if

// file: logic/bmio_irq_collector.sv
/*
 * Four-source interrupt collector: mask, pending status, output gate.
 * Assumes sources already synchronised to clk_i.
 */
module bmio_irq_collector
    import bmio_pkg::*;
(
    input wire logic clk_i,             // Bus clock
    input wire logic nrst_i,            // Async reset, active low
    bmio_irq_if.col bus,                // Register side
    output logic nmi_req_o,             // Request to non-maskable input
    output logic ext_req_o              // Request to external interrupt input
);
    logic [3:0] mask;
    logic [1:0] ctrl;
    logic timer_prev;
    logic timer_latch;
    logic [3:0] pending;
    logic any_req;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask <= BMIO_MASK_RST[3:0];
        end else if (bus.mask_we) begin
            mask <= bus.mask_wdata;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= BMIO_CTRL_RST;
        end else if (bus.ctrl_we) begin
            ctrl <= bus.ctrl_wdata;
        end
    end

    // Rising edge latch; a new edge beats a same-cycle clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_prev <= 1'b0;
            timer_latch <= 1'b0;
        end else begin
            timer_prev <= bus.src[BMIO_SRC_TIMER];
            if (bus.src[BMIO_SRC_TIMER] && !timer_prev) begin
                timer_latch <= 1'b1;
            end else if (bus.clr[BMIO_SRC_TIMER]) begin
                timer_latch <= 1'b0;
            end
        end
    end

    always_comb begin
        pending = 4'h0;
        pending[BMIO_SRC_TIMER] = timer_latch;
        pending[BMIO_SRC_UART] = bus.src[BMIO_SRC_UART];
        pending[BMIO_SRC_TOV] = bus.src[BMIO_SRC_TOV];
        pending[BMIO_SRC_XINT] = !bus.src[BMIO_SRC_XINT];
    end

    assign any_req = |(pending & mask);
    assign nmi_req_o = any_req && ctrl[BMIO_CTRL_GATE] && !ctrl[BMIO_CTRL_SEL];
    assign ext_req_o = any_req && ctrl[BMIO_CTRL_GATE] && ctrl[BMIO_CTRL_SEL];
    assign bus.mask = mask;
    assign bus.pending = pending;
    assign bus.ctrl = ctrl;

    gate_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !ctrl[BMIO_CTRL_GATE] |-> !nmi_req_o && !ext_req_o)
        else $error("request seen with gate closed");
    edge_latch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(bus.src[BMIO_SRC_TIMER]) |=> pending[BMIO_SRC_TIMER])
        else $error("timer edge not latched");
    clr_timer_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        bus.clr[BMIO_SRC_TIMER] && !(bus.src[BMIO_SRC_TIMER] && !timer_prev)
        |=> !pending[BMIO_SRC_TIMER])
        else $error("timer pending not cleared");
endmodule : bmio_irq_collector

// file: logic/bmio_decoder.sv
/*
 * Board memory and I/O decoder with switch ports, display latch,
 * time-over indicator and interrupt collector.
 * Assumes a synchronous external bus on clk_i: address, strobes and
 * write data valid while cs_strobe_i is high; ready_o ends the access.
 * Switches, straps and interrupt sources are asynchronous pins.
 */
module bmio_decoder
    import bmio_pkg::*;
#(
    parameter int ROM_ADDR_BITS = 17     // Fitted ROM capacity, log2 bytes
) (
    input wire logic clk_i,              // Bus clock, 25 MHz
    input wire logic nrst_i,             // Async reset, active low
    input wire logic [27:0] addr_i,      // Byte address
    input wire logic cs_strobe_i,        // Access in progress
    input wire logic wr_i,               // 1 write, 0 read
    input wire logic [1:0] be_i,         // Byte lanes, bit 1 upper
    input wire logic [15:0] wdata_i,     // Write data
    output logic [15:0] rdata_o,         // Read data
    output logic ready_o,                // Access complete, one cycle
    input wire logic flash_boot_strap_i, // High = flash boot on
    input wire logic slow_clk_strap_i,   // High = slow bus clock
    input wire logic [7:0] switch_bank_a_i, // Bank A, 0 = on
    input wire logic [7:0] switch_bank_b_i, // Bank B, 0 = on
    input wire logic timeover_event_i,   // Time-over ready event
    input wire logic uart_irq_i,         // Active high level
    input wire logic timer_channel_zero_output_i, // Rising edge source
    input wire logic expansion_interrupt_zero_n_i, // Active low level
    output logic rom_sel_o,              // Boot ROM select
    output logic [16:0] rom_addr_o,      // ROM address, wrapped
    output logic sram_sel_o,             // SRAM select
    output logic [19:0] sram_addr_o,     // SRAM address, wrapped
    output logic sdram_sel_o,            // SDRAM select
    output logic [24:0] sdram_addr_o,    // SDRAM address, wrapped
    output logic [6:0] exp_sel_n_o,      // Expansion chip selects, low
    output logic uart_sel_o,             // UART window
    output logic timer_sel_o,            // Timer window
    output logic xacc_sel_o,             // Expansion access control
    output logic [15:0] segment_display_o, // Two digit bytes, 0 lights
    output logic timeover_indicator_o,   // Indicator lit
    output logic nmi_req_o,              // Request to non-maskable input
    output logic ext_req_o               // Request to external input
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    ////////////////////////////////////////////////////////////////////
    localparam int SYNC_W = 22;
    // Reset to each pin's idle level; a low expansion line would otherwise
    // show as a pending request for two cycles after reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 22'h00_0001;
    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_s1;
    logic [SYNC_W-1:0] sync_s2;
    assign sync_raw = {flash_boot_strap_i, slow_clk_strap_i, switch_bank_a_i,
                       switch_bank_b_i, timeover_event_i, uart_irq_i,
                       timer_channel_zero_output_i, expansion_interrupt_zero_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    sync_s1[gi] <= SYNC_RST[gi];
                    sync_s2[gi] <= SYNC_RST[gi];
                end else begin
                    sync_s1[gi] <= sync_raw[gi];
                    sync_s2[gi] <= sync_s1[gi];
                end
            end
        end
    endgenerate

    logic flash_boot_strap;
    logic slow;
    logic [7:0] swa;
    logic [7:0] swb;
    logic tov_evt;
    logic [3:0] src_sync;
    assign flash_boot_strap = sync_s2[21];
    assign slow = sync_s2[20];
    assign swa = sync_s2[19:12];
    assign swb = sync_s2[11:4];
    assign tov_evt = sync_s2[3];

    ////////////////////////////////////////////////////////////////////
    // Address decode
    ////////////////////////////////////////////////////////////////////
    function automatic logic in_range(input logic [27:0] a, input logic [27:0] lo,
                                      input logic [27:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic hit(input logic [27:0] a, input logic [27:0] port);
        hit = (a == port);
    endfunction : hit

    logic low_region;
    logic rom_hit;
    logic sram_hit;
    logic sdram_hit;
    logic [3:0] region;
    logic board_hit;
    logic io_region;

    assign low_region = in_range(addr_i, BMIO_ROM_LO, BMIO_ROM_HI);
    assign rom_hit = low_region && !flash_boot_strap;
    assign sram_hit = in_range(addr_i, BMIO_SRAM_LO, BMIO_SRAM_HI);
    // Internal RAM precedence is the processor's job; it never drives out
    assign sdram_hit = in_range(addr_i, BMIO_SDRAM_LO, BMIO_SDRAM_HI);
    assign region = addr_i[27:24];
    assign io_region = ((addr_i & BMIO_REGION_MASK) == BMIO_IO_LO);
    assign board_hit = in_range(addr_i, BMIO_BOARD_LO, BMIO_BOARD_HI);

    // Selects only while strobed; upper lines ignored to alias
    always_comb begin
        rom_sel_o = cs_strobe_i && rom_hit;
        sram_sel_o = cs_strobe_i && sram_hit;
        sdram_sel_o = cs_strobe_i && sdram_hit;
        rom_addr_o = 17'h0_0000;
        rom_addr_o[ROM_ADDR_BITS-1:0] = addr_i[ROM_ADDR_BITS-1:0];
        sram_addr_o = addr_i[19:0];
        sdram_addr_o = addr_i[24:0];
    end

    // Expansion selects, active low. Sub-split of 6/7 windows is left to
    // the expansion card, so selects 3, 2, 4, 6 share their window's enable.
    always_comb begin
        exp_sel_n_o = 7'h7F;
        if (cs_strobe_i) begin
            if ((low_region && flash_boot_strap) || in_range(addr_i, BMIO_XS13_LO, BMIO_XS13_HI)) begin
                exp_sel_n_o[1] = 1'b0;
            end
            if ((addr_i & BMIO_REGION_MASK) == BMIO_XS5_LO) begin
                exp_sel_n_o[5] = 1'b0;
            end
            if ((addr_i & BMIO_REGION_MASK) == BMIO_XS0_LO) begin
                exp_sel_n_o[0] = 1'b0;
            end
            if (in_range(addr_i, BMIO_XS13_LO, BMIO_XS13_HI)) begin
                exp_sel_n_o[3] = 1'b0;
            end
            if (io_region && !board_hit) begin
                exp_sel_n_o[2] = 1'b0;
                exp_sel_n_o[4] = 1'b0;
                exp_sel_n_o[6] = 1'b0;
            end
        end
        // Spaces eight to fifteen leave every select idle
        if (in_range(addr_i, BMIO_UNUSED_LO, BMIO_UNUSED_HI)) begin
            exp_sel_n_o = 7'h7F;
        end
    end

    assign uart_sel_o = cs_strobe_i && in_range(addr_i, BMIO_UART_LO, BMIO_UART_HI);
    assign timer_sel_o = cs_strobe_i && in_range(addr_i, BMIO_TIMER_LO, BMIO_TIMER_HI);
    assign xacc_sel_o = cs_strobe_i && hit(addr_i, BMIO_XACC);

    ////////////////////////////////////////////////////////////////////
    // Wait sequencer
    ////////////////////////////////////////////////////////////////////
    bmio_state_e state;
    logic [3:0] wait_cnt;
    logic [3:0] next_wait;
    logic forced;

    always_comb begin
        forced = 1'b1;
        if (rom_hit) begin
            next_wait = slow ? BMIO_ROM_WAIT_SLOW : BMIO_ROM_WAIT_FAST;
        end else if (board_hit) begin
            next_wait = slow ? BMIO_IO_WAIT_SLOW : BMIO_IO_WAIT_FAST;
        end else begin
            // Processor's own wait settings govern memories
            next_wait = 4'h0;
            forced = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= BMIO_IDLE;
            wait_cnt <= 4'h0;
        end else begin
            case (state)
                BMIO_IDLE: begin
                    if (cs_strobe_i && forced) begin
                        state <= BMIO_WAIT;
                        wait_cnt <= next_wait - 4'h1;
                    end
                end
                BMIO_WAIT: begin
                    if (wait_cnt == 4'h0) begin
                        state <= BMIO_DONE;
                    end else begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end
                end
                BMIO_DONE: begin
                    state <= BMIO_IDLE;
                end
                default: begin
                    state <= BMIO_IDLE;
                end
            endcase
        end
    end

    assign ready_o = (state == BMIO_DONE) || (state == BMIO_IDLE && cs_strobe_i && !forced);

    logic io_wr;
    logic io_rd;
    assign io_wr = (state == BMIO_DONE) && wr_i && board_hit;
    assign io_rd = (state == BMIO_WAIT) && (wait_cnt == 4'h0) && !wr_i;

    ////////////////////////////////////////////////////////////////////
    // Display and time-over latches
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            segment_display_o <= BMIO_SEG_RST;
        end else if (io_wr && hit(addr_i & ~28'h000_0001, BMIO_SEG)) begin
            if (be_i[0] && !addr_i[0]) begin
                segment_display_o[7:0] <= wdata_i[7:0];
            end
            if (be_i[1] || hit(addr_i, BMIO_SEG_HI_BYTE)) begin
                segment_display_o[15:8] <= wdata_i[15:8];
            end
        end
    end

    // Event beats a same-cycle clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timeover_indicator_o <= 1'b0;
        end else if (tov_evt) begin
            timeover_indicator_o <= 1'b1;
        end else if (io_wr && hit(addr_i, BMIO_TOV_CLR)) begin
            timeover_indicator_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt collector and read data
    ////////////////////////////////////////////////////////////////////
    bmio_irq_if irq_bus();
    assign src_sync[BMIO_SRC_TIMER] = sync_s2[1];
    assign src_sync[BMIO_SRC_UART] = sync_s2[2];
    assign src_sync[BMIO_SRC_TOV] = timeover_indicator_o;
    assign src_sync[BMIO_SRC_XINT] = sync_s2[0];
    assign irq_bus.src = src_sync;
    assign irq_bus.mask_we = io_wr && hit(addr_i, BMIO_IRQ_MASK);
    assign irq_bus.mask_wdata = wdata_i[3:0];
    assign irq_bus.clr = (io_wr && hit(addr_i, BMIO_IRQ_STAT)) ? wdata_i[3:0] : 4'h0;
    assign irq_bus.ctrl_we = io_wr && hit(addr_i, BMIO_IRQ_CTRL);
    assign irq_bus.ctrl_wdata = wdata_i[1:0];

    bmio_irq_collector u_irq (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .bus(irq_bus.col),
        .nmi_req_o(nmi_req_o),
        .ext_req_o(ext_req_o)
    );

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 16'h0000;
        end else if (io_rd && board_hit) begin
            rdata_o <= 16'h0000;
            if (hit(addr_i, BMIO_SWA)) begin
                rdata_o[7:0] <= swa;
            end else if (hit(addr_i, BMIO_SWB)) begin
                rdata_o[7:0] <= swb;
            end else if (hit(addr_i, BMIO_IRQ_MASK)) begin
                rdata_o[3:0] <= irq_bus.mask;
            end else if (hit(addr_i, BMIO_IRQ_STAT)) begin
                rdata_o[3:0] <= irq_bus.pending;
            end else if (hit(addr_i, BMIO_IRQ_CTRL)) begin
                rdata_o[1:0] <= irq_bus.ctrl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////
    sequence rom_start_s;
        state == BMIO_IDLE && cs_strobe_i && rom_hit && !slow;
    endsequence
    sequence io_start_s;
        state == BMIO_IDLE && cs_strobe_i && board_hit && !slow;
    endsequence

    rom_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rom_start_s |-> !ready_o ##1 !ready_o [*7] ##1 ready_o)
        else $error("boot ROM wait count wrong");
    // Ten waits split in two runs to keep each repetition short
    io_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        io_start_s |-> !ready_o ##1 !ready_o [*8] ##1 !ready_o [*2] ##1 ready_o)
        else $error("board I/O wait count wrong");
    rom_flash_boot_strap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cs_strobe_i && low_region |-> rom_sel_o != !exp_sel_n_o[1])
        else $error("low region select wrong");
    flash_win_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cs_strobe_i && region == 4'h6 |-> !exp_sel_n_o[1])
        else $error("flash window select missing");
    unused_space_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        addr_i[27] |-> exp_sel_n_o == 7'h7F && !rom_sel_o && !sram_sel_o && !sdram_sel_o)
        else $error("upper spaces selected a resource");
    sram_alias_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sram_sel_o |-> sram_addr_o == addr_i[19:0] && !sdram_sel_o)
        else $error("SRAM decode wrong");
    tov_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        timeover_indicator_o && !(io_wr && hit(addr_i, BMIO_TOV_CLR))
        |=> timeover_indicator_o)
        else $error("indicator dropped without clear");
    switch_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        io_rd && hit(addr_i, BMIO_SWA) |=> rdata_o[7:0] == $past(swa))
        else $error("switch bank A read wrong");
endmodule : bmio_decoder

// file: verification/bmio_host.sv
/* Host bus master model, one access at a time.
   Assumes ready_i ends every access. */
module bmio_host (
    input wire logic clk_i, // Bus clock
    input wire logic ready_i, // Access done
    input wire logic [15:0] rdata_i, // Read data
    output logic [27:0] addr_o, // Address
    output logic cs_o, // Access strobe
    output logic wr_o, // Write
    output logic [1:0] be_o, // Byte lanes
    output logic [15:0] wdata_o // Write data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {addr_o, wr_o, be_o, wdata_o, cs_o} = '0;
    // Internal RAM and processor waits never reach the pins
    task automatic access(input logic [27:0] a, input logic w, input logic [1:0] b,
            input logic [15:0] d, output logic [15:0] rd, output int n);
        n = 0;
        @(posedge clk_i);
        #1;
        {addr_o, wr_o, be_o, wdata_o, cs_o} = {a, w, b, d, 1'b1};
        do begin
            @(posedge clk_i);
            n++;
        end while (ready_i !== 1'b1 && n < 40);
        rd = rdata_i;
        #1;
        // Released lines must not keep their last value
        {addr_o, wr_o, be_o, wdata_o, cs_o} = {~a, ~w, ~b, ~d, 1'b0};
    endtask : access
endmodule : bmio_host

// file: verification/tb.sv
/* Self-checking bench for the board decoder.
   Assumes the host model drives the bus. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bmio_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [27:0] addr_i;
    logic cs_strobe_i, wr_i, ready_o, rom_sel_o, sram_sel_o, sdram_sel_o, uart_sel_o;
    logic [1:0] be_i;
    logic [15:0] wdata_i, rdata_o, segment_display_o, rd_v;
    logic flash_boot_strap_i = 1'b0, slow_clk_strap_i = 1'b0;
    logic [7:0] switch_bank_a_i = 8'hA5, switch_bank_b_i = 8'h3C;
    logic timeover_event_i = 1'b0, uart_irq_i = 1'b0, timer_channel_zero_output_i = 1'b0;
    logic expansion_interrupt_zero_n_i = 1'b1, timer_sel_o, xacc_sel_o;
    logic timeover_indicator_o, nmi_req_o, ext_req_o;
    logic [16:0] rom_addr_o;
    logic [19:0] sram_addr_o;
    logic [24:0] sdram_addr_o;
    logic [6:0] exp_sel_n_o;
    logic [12:0] sel_q;
    logic [61:0] adr_q;
    int n_mismatch = 0, total_checks = 0, cyc_v, w_v;
    localparam logic [27:0] DA [11] = '{28'h03B_1234, 28'h05A_BCDE, 28'h2A3_4567, BMIO_XS5_LO,
        BMIO_XS0_LO, BMIO_XS13_LO, BMIO_IO_LO, BMIO_UNUSED_LO, BMIO_UART_LO, BMIO_TIMER_LO,
        BMIO_XACC};
    localparam logic [12:0] DS [11] = '{13'h13F8, 13'h0BF8, 13'h07F8, 13'h02F8, 13'h03F0,
        13'h03A8, 13'h0158, 13'h03F8, 13'h03FC, 13'h03FA, 13'h03F9};
    wire [12:0] sel_w = {rom_sel_o, sram_sel_o, sdram_sel_o, exp_sel_n_o, uart_sel_o,
        timer_sel_o, xacc_sel_o};
    wire [2:0] req_w = {timeover_indicator_o, ext_req_o, nmi_req_o};
    always #20 clk_i = ~clk_i;
    bmio_decoder #(.ROM_ADDR_BITS(17)) i_dut (.clk_i, .nrst_i, .addr_i, .cs_strobe_i, .wr_i,
        .be_i, .wdata_i, .rdata_o, .ready_o, .flash_boot_strap_i, .slow_clk_strap_i,
        .switch_bank_a_i, .switch_bank_b_i, .timeover_event_i, .uart_irq_i,
        .timer_channel_zero_output_i, .expansion_interrupt_zero_n_i, .rom_sel_o, .rom_addr_o,
        .sram_sel_o, .sram_addr_o, .sdram_sel_o, .sdram_addr_o, .exp_sel_n_o, .uart_sel_o,
        .timer_sel_o, .xacc_sel_o, .segment_display_o, .timeover_indicator_o, .nmi_req_o,
        .ext_req_o);
    bmio_host i_host (.clk_i, .ready_i(ready_o), .rdata_i(rdata_o), .addr_o(addr_i),
        .cs_o(cs_strobe_i), .wr_o(wr_i), .be_o(be_i), .wdata_o(wdata_i));
    // Selects are only meaningful while strobed, so grab them in the ready cycle
    always @(posedge clk_i) begin
        if (ready_o === 1'b1) begin
            sel_q <= sel_w;
            adr_q <= {rom_addr_o, sram_addr_o, sdram_addr_o};
        end
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic acc(input logic [27:0] a, input logic w, input logic [15:0] d);
        i_host.access(a, w, 2'b11, d, rd_v, cyc_v);
    endtask : acc
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        #500_000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        tick(16);
        nrst_i = 1'b1;
        tick(3);
        chk("reset state", 19'h7_FFF8, {segment_display_o, req_w});
        for (int s = 0; s < 2; s++) begin
            slow_clk_strap_i = s[0];
            tick(4);
            for (int i = 0; i < 11; i++) begin
                acc(DA[i], 1'b0, 16'h0000);
                chk("selects", DS[i], sel_q);
                if (i < 3) chk("address", {DA[i][16:0], DA[i][19:0], DA[i][24:0]}, adr_q);
                w_v = (i == 0) ? (s ? BMIO_ROM_WAIT_SLOW : BMIO_ROM_WAIT_FAST) : 0;
                if (i > 7) w_v = s ? BMIO_IO_WAIT_SLOW : BMIO_IO_WAIT_FAST;
                chk("cycles", (w_v == 0) ? 1 : w_v + 2, cyc_v);
            end
        end
        flash_boot_strap_i = 1'b1;
        tick(4);
        acc(DA[0], 1'b0, 16'h0000);
        chk("boot selects", 13'h03E8, sel_q);
        acc(DA[5], 1'b0, 16'h0000);
        chk("window selects", 13'h03A8, sel_q);
        acc(BMIO_SWA, 1'b0, 16'h0000);
        chk("bank a", 8'hA5, rd_v[7:0]);
        acc(BMIO_SWB, 1'b0, 16'h0000);
        chk("bank b", 8'h3C, rd_v[7:0]);
        acc(BMIO_SEG, 1'b1, 16'h1234);
        chk("display", 16'h1234, segment_display_o);
        i_host.access(BMIO_SEG_HI_BYTE, 1'b1, 2'b10, 16'hAB00, rd_v, cyc_v);
        chk("display", 16'hAB34, segment_display_o);
        acc(BMIO_IRQ_MASK, 1'b1, 16'h000F);
        acc(BMIO_IRQ_CTRL, 1'b1, 16'h000F);
        acc(BMIO_IRQ_CTRL, 1'b0, 16'h0000);
        chk("control", 4'h3, rd_v[3:0]);
        timeover_event_i = 1'b1;
        tick(1);
        timeover_event_i = 1'b0;
        tick(4);
        chk("lit requests", 3'h6, req_w);
        acc(BMIO_IRQ_STAT, 1'b0, 16'h0000);
        chk("status", 4'h4, rd_v[3:0]);
        acc(BMIO_TOV_CLR, 1'b1, 16'h0000);
        tick(1);
        chk("cleared", 3'h0, req_w);
        timer_channel_zero_output_i = 1'b1;
        tick(4);
        timer_channel_zero_output_i = 1'b0;
        uart_irq_i = 1'b1;
        expansion_interrupt_zero_n_i = 1'b0;
        tick(4);
        acc(BMIO_IRQ_STAT, 1'b0, 16'h0000);
        chk("status", 4'hB, rd_v[3:0]);
        acc(BMIO_IRQ_STAT, 1'b1, 16'h0001);
        acc(BMIO_IRQ_MASK, 1'b1, 16'h0000);
        acc(BMIO_IRQ_STAT, 1'b0, 16'h0000);
        chk("status", 4'hA, rd_v[3:0]);
        chk("masked", 3'h0, req_w);
        acc(BMIO_IRQ_MASK, 1'b1, 16'h0008);
        acc(BMIO_IRQ_CTRL, 1'b1, 16'h0001);
        chk("nmi path", 3'h1, req_w);
        nrst_i = 1'b0;
        tick(2);
        chk("reset state", 19'h7_FFF8, {segment_display_o, req_w});
        finish_test();
    end
endmodule : tb
